// *** common/temp_fault_pkg.sv ***
/*
 Constants for the external temperature fault response block: command
 codes, field positions, reset values, timing counts and the state type.
 Assumes a 40 MHz core clock and a command decoder that presents whole
 command bytes and words.
*/
package temp_fault_pkg;
   localparam logic [7:0] CMD_OT_RESP = 8'h50;
   localparam logic [7:0] CMD_UT_RESP = 8'h54;
   localparam logic [7:0] CMD_PROP_MASK = 8'hD2;
   localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
   localparam logic [7:0] CMD_STATUS_TEMP = 8'h7D;

   localparam logic [7:0] RESP_RESET = 8'hB8;
   localparam logic [15:0] PROP_RESET = 16'h2993;

   localparam int RESP_MSB = 7;
   localparam int RESP_LSB = 6;
   localparam int RETRY_MSB = 5;
   localparam int RETRY_LSB = 3;
   localparam logic [1:0] RESP_CONTINUE = 2'h0;
   localparam logic [1:0] RESP_BAD_A = 2'h1;
   localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
   localparam logic [1:0] RESP_BAD_B = 2'h3;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;

   localparam int STB_TEMP_BIT = 2;
   localparam int STT_OT_BIT = 7;
   localparam int STT_UT_BIT = 4;
   localparam int PROP_OT_BIT = 7;
   localparam int PROP_UT_BIT = 8;

   localparam int TEMP_W = 16;
   localparam int CLK_HZ = 40000000;
   localparam int RETRY_UNIT_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * RETRY_UNIT_MS;
   localparam int RESPONSE_TIME_MS = 80;

   typedef enum logic [2:0] {
      ST_REGULATE = 3'h1,
      ST_LATCHED = 3'h2,
      ST_RETRY = 3'h4
   } out_state_type;
endpackage

// *** verilog/pin_sync.sv ***
/*
 Two-flop synchroniser for a bundle of pins.
 Assumes each bit is sampled alone; a bus is only trusted once it has
 been stable for longer than two clock periods.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] sync_o
);
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic meta_q;
         logic sync_q;
         always_ff @(posedge mclk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else if (ce_i) begin
               meta_q <= pin_i[g];
               sync_q <= meta_q;
            end
         end
         assign sync_o[g] = sync_q;
      end
   endgenerate
endmodule
`default_nettype wire

// *** verilog/retry_timer.sv ***
/*
 Retry interval timer: a start pulse loads the interval in milliseconds,
 done pulses once when it has run out.
 Assumes start is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module retry_timer #(
   parameter int TICK_CYCLES = temp_fault_pkg::TICK_CYCLES
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire logic [15:0] delay_ms_i,
   output logic done_o
);
   logic [23:0] tick_q;
   logic [15:0] ms_q;
   logic busy_q;
   logic tick_end;

   assign tick_end = (tick_q == 24'(TICK_CYCLES - 1));

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tick_q <= 24'h000000;
         ms_q <= 16'h0000;
         busy_q <= 1'b0;
         done_o <= 1'b0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         if (start_i) begin
            tick_q <= 24'h000000;
            ms_q <= delay_ms_i;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            // A zero interval still waits one tick so restarts never storm
            if (tick_end) begin
               tick_q <= 24'h000000;
               if (ms_q <= 16'h0001) begin
                  busy_q <= 1'b0;
                  done_o <= 1'b1;
               end else begin
                  ms_q <= ms_q - 16'h0001;
               end
            end else begin
               tick_q <= tick_q + 24'h000001;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** verilog/temp_fault_response.sv ***
/*
 External temperature fault response: limit compare at each conversion,
 sticky status bits, alert and fault-pin drive, response and propagation
 registers on the command port, and output shutdown with retry.
 Assumes the command port, limits, retry interval and on command come
 from logic on mclk_i; the conversion strobe and reading come from pins.
*/
// How it works
// R1: Either fault sets temperature summary bit
// R2: Overtemperature fault sets its status bit
// R3: Undertemperature fault sets its status bit
// R4: Every fault pulls the alert low
// R5: Response follows conversion, well within 80ms
// R6: Code 00 keeps output regulating
// R7: Codes 01 and 11 raise CML
// R8: Code 10 disables output, then retry
// R9: Retry 000 latches off until cleared
// R10: Retry 111 restarts until off or fatal
// R11: Restart spacing uses retry interval input
// R12: Delay field bits ignored
// R13: Fault bits sticky until clear or cycle
// R14: Overtemperature response byte, default B8
// R15: Undertemperature response byte, same layout
// R16: Sixteen-bit propagation mask, default 2993
// R17: Only responding faults reach fault pin
// R18: Compare reading with limits each conversion
`timescale 1ns/1ps
`default_nettype none
module temp_fault_response #(
   parameter int TICK_CYCLES = temp_fault_pkg::TICK_CYCLES
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic conv_done_i,
   input wire logic [15:0] temp_i,
   input wire logic [15:0] ot_limit_i,
   input wire logic [15:0] ut_limit_i,
   input wire logic [15:0] retry_delay_ms_i,
   input wire logic on_cmd_i,
   input wire logic clear_faults_i,
   input wire logic cmd_wr_i,
   input wire logic cmd_rd_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic [15:0] cmd_wdata_i,
   output logic [15:0] cmd_rdata_o,
   output logic cmd_ack_o,
   output logic cml_fault_o,
   output logic output_en_o,
   output logic alert_n_o,
   output logic fault_pin_n_o
);
   logic [16:0] pins_s;
   logic conv_prev_q;
   logic conv_edge;
   logic on_prev_q;
   logic clr;
   logic ot_hit;
   logic ut_hit;
   logic ot_flag_q;
   logic ut_flag_q;
   logic [7:0] ot_resp_q;
   logic [7:0] ut_resp_q;
   logic [15:0] prop_mask_q;
   logic ot_shut;
   logic ut_shut;
   logic trip;
   logic trip_forever;
   logic timer_done;
   logic timer_start;
   logic bad_wr;
   temp_fault_pkg::out_state_type state_q;
   temp_fault_pkg::out_state_type state_d;

   function automatic logic [1:0] resp_of(input logic [7:0] cfg);
      resp_of = cfg[temp_fault_pkg::RESP_MSB:temp_fault_pkg::RESP_LSB];
   endfunction

   function automatic logic retries(input logic [7:0] cfg);
      retries = cfg[temp_fault_pkg::RETRY_MSB:temp_fault_pkg::RETRY_LSB]
                == temp_fault_pkg::RETRY_FOREVER;
   endfunction

   function automatic logic bad_code(input logic [7:0] cfg);
      bad_code = resp_of(cfg) == temp_fault_pkg::RESP_BAD_A ||
                 resp_of(cfg) == temp_fault_pkg::RESP_BAD_B;
   endfunction

   pin_sync #(
      .W(17)
   ) u_sync (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .pin_i({conv_done_i, temp_i}),
      .sync_o(pins_s)
   );

   // R5: acts in conversion cycle
   // R18: limit compare per conversion
   assign conv_edge = pins_s[16] & ~conv_prev_q;
   assign ot_hit = conv_edge && ($signed(pins_s[15:0]) >= $signed(ot_limit_i));
   assign ut_hit = conv_edge && ($signed(pins_s[15:0]) <= $signed(ut_limit_i));
   assign clr = clear_faults_i | (on_cmd_i & ~on_prev_q);

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         conv_prev_q <= 1'b0;
         on_prev_q <= 1'b0;
      end else if (ce_i) begin
         conv_prev_q <= pins_s[16];
         on_prev_q <= on_cmd_i;
      end
   end

   // R13: sticky, set beats clear
   // R2: overtemperature status
   // R3: undertemperature status
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ot_flag_q <= 1'b0;
         ut_flag_q <= 1'b0;
      end else if (ce_i) begin
         ot_flag_q <= ot_hit | (ot_flag_q & ~clr);
         ut_flag_q <= ut_hit | (ut_flag_q & ~clr);
      end
   end

   // R7: reject unsupported codes
   assign bad_wr = cmd_wr_i &&
                   ((cmd_code_i == temp_fault_pkg::CMD_OT_RESP) ||
                    (cmd_code_i == temp_fault_pkg::CMD_UT_RESP)) &&
                   bad_code(cmd_wdata_i[7:0]);

   // R14: overtemperature response byte
   // R15: undertemperature response byte
   // R16: propagation mask word
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ot_resp_q <= temp_fault_pkg::RESP_RESET;
         ut_resp_q <= temp_fault_pkg::RESP_RESET;
         prop_mask_q <= temp_fault_pkg::PROP_RESET;
         cml_fault_o <= 1'b0;
      end else if (ce_i) begin
         cml_fault_o <= bad_wr;
         // A rejected byte leaves the old response in force
         if (cmd_wr_i && !bad_wr) begin
            case (cmd_code_i)
               temp_fault_pkg::CMD_OT_RESP: begin
                  ot_resp_q <= cmd_wdata_i[7:0];
               end
               temp_fault_pkg::CMD_UT_RESP: begin
                  ut_resp_q <= cmd_wdata_i[7:0];
               end
               temp_fault_pkg::CMD_PROP_MASK: begin
                  prop_mask_q <= cmd_wdata_i;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // R1: summary bit in status byte
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cmd_rdata_o <= 16'h0000;
         cmd_ack_o <= 1'b0;
      end else if (ce_i) begin
         cmd_ack_o <= cmd_wr_i | cmd_rd_i;
         cmd_rdata_o <= 16'h0000;
         if (cmd_rd_i) begin
            case (cmd_code_i)
               temp_fault_pkg::CMD_OT_RESP: cmd_rdata_o <= {8'h00, ot_resp_q};
               temp_fault_pkg::CMD_UT_RESP: cmd_rdata_o <= {8'h00, ut_resp_q};
               temp_fault_pkg::CMD_PROP_MASK: cmd_rdata_o <= prop_mask_q;
               temp_fault_pkg::CMD_STATUS_BYTE: begin
                  cmd_rdata_o[temp_fault_pkg::STB_TEMP_BIT] <= ot_flag_q | ut_flag_q;
               end
               temp_fault_pkg::CMD_STATUS_TEMP: begin
                  cmd_rdata_o[temp_fault_pkg::STT_OT_BIT] <= ot_flag_q;
                  cmd_rdata_o[temp_fault_pkg::STT_UT_BIT] <= ut_flag_q;
               end
               default: cmd_rdata_o <= 16'h0000;
            endcase
         end
      end
   end

   // R6: code 00 never shuts down
   // R12: delay bits never read
   assign ot_shut = ot_hit && resp_of(ot_resp_q) == temp_fault_pkg::RESP_SHUTDOWN;
   assign ut_shut = ut_hit && resp_of(ut_resp_q) == temp_fault_pkg::RESP_SHUTDOWN;
   assign trip = ot_shut | ut_shut;
   // A fault set for no retry overrides one that would retry
   assign trip_forever = (!ot_shut || retries(ot_resp_q)) &&
                         (!ut_shut || retries(ut_resp_q));

   // R8: shut down then retry
   // R9: latch off without retry
   // R10: endless retry
   always_comb begin
      state_d = state_q;
      case (state_q)
         temp_fault_pkg::ST_REGULATE: begin
            if (on_cmd_i && trip) begin
               state_d = trip_forever ? temp_fault_pkg::ST_RETRY :
                                        temp_fault_pkg::ST_LATCHED;
            end
         end
         temp_fault_pkg::ST_LATCHED: begin
            // A fresh trip beats a clear in the same cycle
            if (!on_cmd_i || (clr && !trip)) begin
               state_d = temp_fault_pkg::ST_REGULATE;
            end
         end
         temp_fault_pkg::ST_RETRY: begin
            if (!on_cmd_i) begin
               state_d = temp_fault_pkg::ST_REGULATE;
            end else if (trip) begin
               state_d = trip_forever ? temp_fault_pkg::ST_RETRY :
                                        temp_fault_pkg::ST_LATCHED;
            end else if (timer_done) begin
               state_d = temp_fault_pkg::ST_REGULATE;
            end
         end
         default: state_d = temp_fault_pkg::ST_LATCHED;
      endcase
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= temp_fault_pkg::ST_REGULATE;
         output_en_o <= 1'b0;
      end else if (ce_i) begin
         state_q <= state_d;
         output_en_o <= on_cmd_i && (state_d == temp_fault_pkg::ST_REGULATE);
      end
   end

   // R11: spacing from retry interval
   // A trip during the wait restarts the interval so the timer never idles in retry
   assign timer_start = ce_i && state_d == temp_fault_pkg::ST_RETRY &&
                        (state_q != temp_fault_pkg::ST_RETRY || trip);

   retry_timer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_timer (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .start_i(timer_start),
      .delay_ms_i(retry_delay_ms_i),
      .done_o(timer_done)
   );

   // R4: alert on any fault
   // R17: propagate only responding faults
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         alert_n_o <= 1'b1;
         fault_pin_n_o <= 1'b1;
      end else if (ce_i) begin
         alert_n_o <= ~(ot_flag_q | ut_flag_q);
         fault_pin_n_o <= ~((ot_flag_q && prop_mask_q[temp_fault_pkg::PROP_OT_BIT] &&
                             resp_of(ot_resp_q) == temp_fault_pkg::RESP_SHUTDOWN) ||
                            (ut_flag_q && prop_mask_q[temp_fault_pkg::PROP_UT_BIT] &&
                             resp_of(ut_resp_q) == temp_fault_pkg::RESP_SHUTDOWN));
      end
   end

   ot_flag_set_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R2
      ce_i && ot_hit |=> ot_flag_q)
      else $error("overtemperature flag not set");
   ut_flag_hold_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R13
      ut_flag_q && !clr && ce_i |=> ut_flag_q)
      else $error("undertemperature flag dropped without clear");
   alert_follows_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R4
      ce_i && ot_hit ##1 ce_i |=> !alert_n_o)
      else $error("alert not asserted after fault");
   shutdown_now_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R8
      ce_i && trip |=> !output_en_o)
      else $error("output not disabled on shutdown fault");
   continue_run_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R6
      ce_i && on_cmd_i && state_q == temp_fault_pkg::ST_REGULATE && !trip
      |=> output_en_o)
      else $error("output dropped without shutdown response");
   cml_bad_code_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R7
      ce_i && bad_wr |=> cml_fault_o && $stable(ot_resp_q) && $stable(ut_resp_q))
      else $error("unsupported response code accepted");
   latched_off_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R9
      state_q == temp_fault_pkg::ST_LATCHED && on_cmd_i && !clr |=> !output_en_o)
      else $error("latched output restarted");
   propagate_gate_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R17
      ce_i && resp_of(ot_resp_q) != temp_fault_pkg::RESP_SHUTDOWN &&
      resp_of(ut_resp_q) != temp_fault_pkg::RESP_SHUTDOWN |=> fault_pin_n_o)
      else $error("fault pin driven by non-responding fault");
   retry_start_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R10
      ce_i && on_cmd_i && state_q == temp_fault_pkg::ST_REGULATE && trip &&
      trip_forever |=> state_q == temp_fault_pkg::ST_RETRY)
      else $error("retry not entered");
   summary_read_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R1
      ce_i && cmd_rd_i && cmd_code_i == temp_fault_pkg::CMD_STATUS_BYTE &&
      (ot_flag_q || ut_flag_q) |=> cmd_rdata_o[temp_fault_pkg::STB_TEMP_BIT])
      else $error("temperature summary bit missing");
endmodule
`default_nettype wire

// *** tb/conv_model.sv ***
/*
 Behavioural temperature converter on the far side of the conversion pins.
 Assumes the bench toggles go_i to request one conversion of value_i.
*/
`timescale 1ns/1ps
`default_nettype none
module conv_model (
   input wire logic go_i,
   input wire logic [15:0] value_i,
   output logic busy_o,
   output logic conv_done_o,
   output logic [15:0] temp_o
);
   logic link_clk;
   logic go_seen;
   initial begin
      link_clk = 1'b0;
      forever #100 link_clk = ~link_clk;
   end
   initial begin
      go_seen = 1'b0;
      busy_o = 1'b0;
      conv_done_o = 1'b0;
      temp_o = 16'h5A5A;
      forever begin
         @(posedge link_clk);
         if (go_i != go_seen) begin
            go_seen = go_i;
            busy_o = 1'b1;
            temp_o = value_i;
            @(posedge link_clk);
            conv_done_o = 1'b1;
            @(posedge link_clk);
            conv_done_o = 1'b0;
            // Stale data is inverted so it is never mistaken for a reading
            temp_o = ~value_i;
            busy_o = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/tb_temp_fault_response.sv ***
/*
 Self-checking bench for the temperature fault response block.
 Assumes TICK_CYCLES of 4 so that one millisecond of retry is 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_temp_fault_response;
   logic mclk_i, nrst_i, ce_i, conv_done_i, on_cmd_i, clear_faults_i;
   logic cmd_wr_i, cmd_rd_i, cmd_ack_o, cml_fault_o, output_en_o;
   logic alert_n_o, fault_pin_n_o, go, busy, cml_seen;
   logic [15:0] temp_i, ot_limit_i, ut_limit_i, retry_delay_ms_i;
   logic [15:0] cmd_wdata_i, cmd_rdata_o, value, rdata;
   logic [7:0] cmd_code_i;
   int mismatches, num_checks, n;

   temp_fault_response #(.TICK_CYCLES(4)) uut (
      .mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .conv_done_i(conv_done_i),
      .temp_i(temp_i), .ot_limit_i(ot_limit_i), .ut_limit_i(ut_limit_i),
      .retry_delay_ms_i(retry_delay_ms_i), .on_cmd_i(on_cmd_i),
      .clear_faults_i(clear_faults_i), .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i),
      .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i), .cmd_rdata_o(cmd_rdata_o),
      .cmd_ack_o(cmd_ack_o), .cml_fault_o(cml_fault_o), .output_en_o(output_en_o),
      .alert_n_o(alert_n_o), .fault_pin_n_o(fault_pin_n_o));
   conv_model model (.go_i(go), .value_i(value), .busy_o(busy),
      .conv_done_o(conv_done_i), .temp_o(temp_i));

   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge mclk_i);
      #1;
   endtask

   task automatic access(input logic w, input logic [7:0] code, input logic [15:0] wd);
      @(posedge mclk_i);
      cmd_wr_i <= w;
      cmd_rd_i <= ~w;
      cmd_code_i <= code;
      cmd_wdata_i <= wd;
      @(posedge mclk_i);
      cmd_wr_i <= 1'b0;
      cmd_rd_i <= 1'b0;
      #1;
      rdata = cmd_rdata_o;
      cml_seen = cml_fault_o;
      check({15'h0, cmd_ack_o}, 16'h1);
   endtask

   task automatic rd(input logic [7:0] code, input logic [15:0] exp);
      access(1'b0, code, 16'h0);
      check(rdata, exp);
   endtask

   task automatic wr(input logic [7:0] code, input logic [15:0] d, input logic c);
      access(1'b1, code, d);
      check({15'h0, cml_seen}, {15'h0, c});
   endtask

   // Bounded wait on a level; a hang counts as a mismatch
   task automatic wait_lvl(input logic lvl, input logic use_en);
      n = 0;
      while ((use_en ? output_en_o : busy) !== lvl && n < 1000) begin
         @(posedge mclk_i);
         n++;
      end
      if (n >= 1000) begin
         mismatches++;
         finish_test();
      end
   endtask

   task automatic conv(input logic [15:0] t);
      @(posedge mclk_i);
      value <= t;
      go <= ~go;
      wait_lvl(1'b1, 1'b0);
      wait_lvl(1'b0, 1'b0);
      tick(4);
   endtask

   task automatic clear;
      @(posedge mclk_i);
      clear_faults_i <= 1'b1;
      @(posedge mclk_i);
      clear_faults_i <= 1'b0;
      tick(2);
   endtask

   initial begin
      nrst_i = 1'b0;
      ce_i = 1'b1;
      on_cmd_i = 1'b1;
      clear_faults_i = 1'b0;
      cmd_wr_i = 1'b0;
      cmd_rd_i = 1'b0;
      cmd_code_i = 8'h00;
      cmd_wdata_i = 16'h0000;
      ot_limit_i = 16'h0100;
      ut_limit_i = 16'hFF00;
      retry_delay_ms_i = 16'h0005;
      go = 1'b0;
      value = 16'h0000;
      mismatches = 0;
      num_checks = 0;
      repeat (8) @(posedge mclk_i);
      nrst_i <= 1'b1;
      rd(temp_fault_pkg::CMD_OT_RESP, 16'h00B8);
      rd(temp_fault_pkg::CMD_UT_RESP, 16'h00B8);
      rd(temp_fault_pkg::CMD_PROP_MASK, 16'h2993);
      rd(8'h33, 16'h0000);
      wait_lvl(1'b1, 1'b1);
      for (int i = 0; i < 2; i++) begin
         wr(i ? 8'h54 : 8'h50, 16'h0040, 1'b1);
         wr(i ? 8'h54 : 8'h50, 16'h00C0, 1'b1);
         rd(i ? 8'h54 : 8'h50, 16'h00B8);
      end
      // Continue code with all delay bits set
      wr(temp_fault_pkg::CMD_OT_RESP, 16'h0007, 1'b0);
      conv(16'h0200);
      check({15'h0, output_en_o}, 16'h1);
      check({15'h0, alert_n_o}, 16'h0);
      check({15'h0, fault_pin_n_o}, 16'h1);
      rd(temp_fault_pkg::CMD_STATUS_BYTE, 16'h0004);
      rd(temp_fault_pkg::CMD_STATUS_TEMP, 16'h0080);
      conv(16'h0000);
      rd(temp_fault_pkg::CMD_STATUS_TEMP, 16'h0080);
      clear();
      rd(temp_fault_pkg::CMD_STATUS_BYTE, 16'h0000);
      check({15'h0, alert_n_o}, 16'h1);
      // Shutdown without retry latches off
      wr(temp_fault_pkg::CMD_UT_RESP, 16'h0087, 1'b0);
      conv(16'hFE00);
      check({15'h0, output_en_o}, 16'h0);
      check({15'h0, alert_n_o}, 16'h0);
      check({15'h0, fault_pin_n_o}, 16'h0);
      rd(temp_fault_pkg::CMD_STATUS_TEMP, 16'h0010);
      rd(temp_fault_pkg::CMD_STATUS_BYTE, 16'h0004);
      tick(200);
      check({15'h0, output_en_o}, 16'h0);
      clear();
      wait_lvl(1'b1, 1'b1);
      check({15'h0, output_en_o}, 16'h1);
      // Two retries with different intervals; part of each has already run
      wr(temp_fault_pkg::CMD_OT_RESP, 16'h00B8, 1'b0);
      for (int d = 5; d <= 10; d += 5) begin
         @(posedge mclk_i);
         retry_delay_ms_i <= 16'(d);
         conv(16'h0200);
         check({15'h0, output_en_o}, 16'h0);
         wait_lvl(1'b1, 1'b1);
         check({15'h0, n >= d * 4 - 12 && n <= d * 4 - 2}, 16'h1);
      end
      check({15'h0, output_en_o}, 16'h1);
      on_cmd_i <= 1'b0;
      tick(4);
      check({15'h0, output_en_o}, 16'h0);
      @(posedge mclk_i);
      on_cmd_i <= 1'b1;
      tick(3);
      rd(temp_fault_pkg::CMD_STATUS_BYTE, 16'h0000);
      wait_lvl(1'b1, 1'b1);
      // Empty mask keeps the fault pin quiet
      wr(temp_fault_pkg::CMD_PROP_MASK, 16'h0000, 1'b0);
      rd(temp_fault_pkg::CMD_PROP_MASK, 16'h0000);
      wr(temp_fault_pkg::CMD_UT_RESP, 16'h0080, 1'b0);
      conv(16'hFE00);
      check({15'h0, output_en_o}, 16'h0);
      check({15'h0, fault_pin_n_o}, 16'h1);
      // A frozen clock enable swallows the clear
      @(posedge mclk_i);
      ce_i <= 1'b0;
      clear();
      check({15'h0, output_en_o}, 16'h0);
      @(posedge mclk_i);
      ce_i <= 1'b1;
      rd(temp_fault_pkg::CMD_STATUS_TEMP, 16'h0010);
      finish_test();
   end
endmodule
`default_nettype wire
